// *** design/ttcu_map.vh ***
`ifndef TTCU_MAP_VH
`define TTCU_MAP_VH
`define TTCU_A_TCTL   8'h88
`define TTCU_A_TMODE  8'h89
`define TTCU_A_T0LO   8'h8a
`define TTCU_A_T1LO   8'h8b
`define TTCU_A_T0HI   8'h8c
`define TTCU_A_T1HI   8'h8d
`define TTCU_A_TWOCTL 8'hc8
`define TTCU_A_TWOMOD 8'hc9
`define TTCU_A_CAPLO  8'hca
`define TTCU_A_CAPHI  8'hcb
`define TTCU_A_TWOLO  8'hcc
`define TTCU_A_TWOHI  8'hcd
`define TTCU_B_OVF1   7
`define TTCU_B_RUN1   6
`define TTCU_B_OVF0   5
`define TTCU_B_RUN0   4
`define TTCU_B_XF1    3
`define TTCU_B_XT1    2
`define TTCU_B_XF0    1
`define TTCU_B_XT0    0
`define TTCU_B_TF2    7
`define TTCU_B_TIMER_TWO_EXTERNAL_FLAG   6
`define TTCU_B_RXSEL  5
`define TTCU_B_TXSEL  4
`define TTCU_B_TRGEN  3
`define TTCU_B_RUN2   2
`define TTCU_B_CSEL2  1
`define TTCU_B_CPRL   0
`define TTCU_B_OE     1
`define TTCU_B_DOWN_COUNT_ENABLE   0
`define TTCU_RST      8'h00
`define TTCU_MC_DIV   6
`endif

// *** design/ttcu_top.v ***
`timescale 1ns/10ps
`include "ttcu_map.vh"
module ttcu_top #(
   parameter MC_DIV = `TTCU_MC_DIV
)(
   input  wire       MCLK,
   input  wire       RSTN,
   input  wire [7:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR,
   input  wire       RD,
   output reg  [7:0] RDATA,
   input  wire       T0_COUNT_PIN,
   input  wire       T1_COUNT_PIN,
   input  wire       EXT_INTERRUPT_PIN_ZERO_N,
   input  wire       EXT_INTERRUPT_PIN_ONE_N,
   input  wire       TIMER_TWO_COUNT_PIN,
   input  wire       TIMER_TWO_TRIGGER_PIN,
   input  wire       ACK_T0,
   input  wire       ACK_T1,
   input  wire       ACK_X0,
   input  wire       ACK_X1,
   output wire       IRQ_T0,
   output wire       IRQ_T1,
   output wire       IRQ_X0,
   output wire       IRQ_X1,
   output reg        IRQ_T2,
   output reg        RX_BAUD_TICK,
   output reg        TX_BAUD_TICK,
   output reg        TIMER_TWO_CLK_OUT,
   output reg        TIMER_TWO_CLK_OE_N
);
   localparam [31:0] MC_SPAN = MC_DIV - 1;
   localparam [7:0]  MC_LAST = MC_SPAN[7:0];

   // Address match for the register strobes
   function hit;
      input [7:0] a;
      input [7:0] r;
   begin
      hit = (a == r);
   end
   endfunction

   function [16:0] tstep;
      input [1:0] m;
      input [7:0] hi;
      input [7:0] lo;
      input       en;
      reg [16:0] s;
      reg [13:0] w13;
      reg [16:0] w17;
      reg [8:0]  w9;
   begin
      s   = {1'b0, hi, lo};
      w13 = {1'b0, hi, lo[4:0]} + 14'h1;
      w17 = {1'b0, hi, lo} + 17'h1;
      w9  = {1'b0, lo} + 9'h1;
      if (en)
      begin
         case (m)
            2'd0:    s = {w13[13], w13[12:5], lo[7:5], w13[4:0]};
            2'd1:    s = w17;
            2'd2:    s = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, w9[7:0]};
            default: s = {w9[8], hi, w9[7:0]};
         endcase
      end
      tstep = s;
   end
   endfunction

   reg  [5:0]  pin_m_q;
   reg  [5:0]  pin_s_q;
   reg  [5:0]  samp_q;
   reg  [7:0]  mc_q;
   reg  [7:0]  tctl_q;
   reg  [7:0]  tmode_q;
   reg  [7:0]  t0lo_q;
   reg  [7:0]  t0hi_q;
   reg  [7:0]  t1lo_q;
   reg  [7:0]  t1hi_q;
   reg  [7:0]  t2ctl_q;
   reg  [1:0]  timer_two_mode_ctrl_q;
   reg  [15:0] cnt_q;
   reg  [15:0] cap_q;
   reg  [15:0] cnt_d;
   reg  [15:0] cap_d;
   reg         ovf2;
   reg  [7:0]  tctl_d;
   reg  [7:0]  t2ctl_d;
   reg  [7:0]  rd_mux;

   wire        mc_tick = (mc_q == MC_LAST);
   // Pins are sampled once per machine cycle; a level must last one cycle to be seen
   wire [5:0]  fall = {6{mc_tick}} & samp_q & ~pin_s_q;

   wire        wr_tctl  = WR & hit(ADDR, `TTCU_A_TCTL);
   wire        wr_tmode = WR & hit(ADDR, `TTCU_A_TMODE);
   wire        wr_t0lo  = WR & hit(ADDR, `TTCU_A_T0LO);
   wire        wr_t0hi  = WR & hit(ADDR, `TTCU_A_T0HI);
   wire        wr_t1lo  = WR & hit(ADDR, `TTCU_A_T1LO);
   wire        wr_t1hi  = WR & hit(ADDR, `TTCU_A_T1HI);
   wire        wr_t2ctl = WR & hit(ADDR, `TTCU_A_TWOCTL);
   wire        wr_timer_two_mode_ctrl = WR & hit(ADDR, `TTCU_A_TWOMOD);
   wire        wr_caplo = WR & hit(ADDR, `TTCU_A_CAPLO);
   wire        wr_caphi = WR & hit(ADDR, `TTCU_A_CAPHI);
   wire        wr_twolo = WR & hit(ADDR, `TTCU_A_TWOLO);
   wire        wr_twohi = WR & hit(ADDR, `TTCU_A_TWOHI);

   wire        run0  = tctl_q[`TTCU_B_RUN0];
   wire        run1  = tctl_q[`TTCU_B_RUN1];
   wire [1:0]  m0    = tmode_q[1:0];
   wire [1:0]  m1    = tmode_q[5:4];
   wire        ct0   = tmode_q[2];
   wire        ct1   = tmode_q[6];
   wire        gate0 = tmode_q[3];
   wire        gate1 = tmode_q[7];
   wire        split = (m0 == 2'd3);

   wire        en0 = run0 & (~gate0 | pin_s_q[2]) & (ct0 ? fall[0] : mc_tick);
   wire        en1 = run1 & (~gate1 | pin_s_q[3]) & (ct1 ? fall[1] : mc_tick)
                   & (m1 != 2'd3);
   wire [16:0] r0  = tstep(m0, t0hi_q, t0lo_q, en0);
   wire [16:0] r1  = tstep(m1, t1hi_q, t1lo_q, en1);
   // Split mode: high byte of timer 0 borrows timer 1's run bit and flag
   wire        en0h = split & run1 & mc_tick;
   wire [8:0]  h0   = {1'b0, t0hi_q} + 9'h1;
   wire        set_tf0 = r0[16];
   wire        set_tf1 = split ? (en0h & h0[8]) : r1[16];
   // Level mode re-arms while the pin stays low, so the flag keeps coming back
   wire        set_x0 = tctl_q[`TTCU_B_XT0] ? fall[2] : ~pin_s_q[2];
   wire        set_x1 = tctl_q[`TTCU_B_XT1] ? fall[3] : ~pin_s_q[3];

   wire        baud   = t2ctl_q[`TTCU_B_RXSEL] | t2ctl_q[`TTCU_B_TXSEL];
   wire        cprl   = t2ctl_q[`TTCU_B_CPRL] & ~baud;
   wire        clko   = timer_two_mode_ctrl_q[`TTCU_B_OE] & ~baud & ~t2ctl_q[`TTCU_B_CPRL];
   wire        updown = timer_two_mode_ctrl_q[`TTCU_B_DOWN_COUNT_ENABLE] & ~baud & ~cprl & ~clko;
   wire        run2   = t2ctl_q[`TTCU_B_RUN2];
   wire        fast   = baud | clko;
   wire        en2    = run2 & (t2ctl_q[`TTCU_B_CSEL2] ? fall[4] : (fast | mc_tick));
   wire        ex_ev  = t2ctl_q[`TTCU_B_TRGEN] & fall[5];

   always @*
   begin
      cnt_d = cnt_q;
      cap_d = cap_q;
      ovf2  = 1'b0;
      if (en2)
      begin
         if (updown & ~pin_s_q[5])
         begin
            if (cnt_q == cap_q)
            begin
               cnt_d = 16'hffff;
               ovf2  = 1'b1;
            end
            else
               cnt_d = cnt_q - 16'h1;
         end
         else if (cnt_q == 16'hffff)
         begin
            ovf2  = 1'b1;
            cnt_d = cprl ? 16'h0000 : cap_q;
         end
         else
            cnt_d = cnt_q + 16'h1;
      end
      // Baud use blocks the trigger reload; direction pin is not a trigger
      if (ex_ev & ~updown & ~baud & ~clko)
      begin
         if (cprl)
            cap_d = cnt_q;
         else
            cnt_d = cap_q;
      end
      if (wr_twolo)
         cnt_d[7:0] = WDATA;
      if (wr_twohi)
         cnt_d[15:8] = WDATA;
      if (wr_caplo)
         cap_d[7:0] = WDATA;
      if (wr_caphi)
         cap_d[15:8] = WDATA;
   end

   always @*
   begin
      // Hardware sets win over software or acknowledge clears in the same cycle
      tctl_d = wr_tctl ? WDATA : tctl_q;
      tctl_d[`TTCU_B_OVF0] = (wr_tctl ? WDATA[`TTCU_B_OVF0] : (tctl_q[`TTCU_B_OVF0] & ~ACK_T0))
                           | set_tf0;
      tctl_d[`TTCU_B_OVF1] = (wr_tctl ? WDATA[`TTCU_B_OVF1] : (tctl_q[`TTCU_B_OVF1] & ~ACK_T1))
                           | set_tf1;
      tctl_d[`TTCU_B_XF0]  = (wr_tctl ? WDATA[`TTCU_B_XF0] : (tctl_q[`TTCU_B_XF0] & ~ACK_X0))
                           | set_x0;
      tctl_d[`TTCU_B_XF1]  = (wr_tctl ? WDATA[`TTCU_B_XF1] : (tctl_q[`TTCU_B_XF1] & ~ACK_X1))
                           | set_x1;
      t2ctl_d = wr_t2ctl ? WDATA : t2ctl_q;
      t2ctl_d[`TTCU_B_TF2]  = t2ctl_d[`TTCU_B_TF2] | (ovf2 & ~fast);
      t2ctl_d[`TTCU_B_TIMER_TWO_EXTERNAL_FLAG] = t2ctl_d[`TTCU_B_TIMER_TWO_EXTERNAL_FLAG]
                            | (ex_ev & ~updown & ~clko)
                            | (ovf2 & updown & ~t2ctl_q[`TTCU_B_TIMER_TWO_EXTERNAL_FLAG]);
      if (ovf2 & updown & t2ctl_q[`TTCU_B_TIMER_TWO_EXTERNAL_FLAG] & ~wr_t2ctl)
         t2ctl_d[`TTCU_B_TIMER_TWO_EXTERNAL_FLAG] = 1'b0;
   end

   always @*
   begin
      case (ADDR)
         `TTCU_A_TCTL:   rd_mux = tctl_q;
         `TTCU_A_TMODE:  rd_mux = tmode_q;
         `TTCU_A_T0LO:   rd_mux = t0lo_q;
         `TTCU_A_T0HI:   rd_mux = t0hi_q;
         `TTCU_A_T1LO:   rd_mux = t1lo_q;
         `TTCU_A_T1HI:   rd_mux = t1hi_q;
         `TTCU_A_TWOCTL: rd_mux = t2ctl_q;
         `TTCU_A_TWOMOD: rd_mux = {6'h00, timer_two_mode_ctrl_q};
         `TTCU_A_CAPLO:  rd_mux = cap_q[7:0];
         `TTCU_A_CAPHI:  rd_mux = cap_q[15:8];
         `TTCU_A_TWOLO:  rd_mux = cnt_q[7:0];
         `TTCU_A_TWOHI:  rd_mux = cnt_q[15:8];
         default:        rd_mux = 8'h00;
      endcase
   end

   assign IRQ_T0 = tctl_q[`TTCU_B_OVF0];
   assign IRQ_T1 = tctl_q[`TTCU_B_OVF1];
   assign IRQ_X0 = tctl_q[`TTCU_B_XF0];
   assign IRQ_X1 = tctl_q[`TTCU_B_XF1];

   // Two flops on every pin before any logic looks at it; idle level is high
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pin_m_q <= 6'h3f;
         pin_s_q <= 6'h3f;
         samp_q  <= 6'h3f;
      end
      else
      begin
         pin_m_q <= {TIMER_TWO_TRIGGER_PIN, TIMER_TWO_COUNT_PIN, EXT_INTERRUPT_PIN_ONE_N,
                     EXT_INTERRUPT_PIN_ZERO_N, T1_COUNT_PIN, T0_COUNT_PIN};
         pin_s_q <= pin_m_q;
         // One sample per machine cycle, so a pin edge costs up to two cycles
         if (mc_tick)
            samp_q <= pin_s_q;
      end
   end

   // Machine-cycle divider; every timer step waits for its last count, except timer 2 on the internal clock in baud or clock-out mode
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         mc_q <= 8'h00;
      else if (mc_tick)
         mc_q <= 8'h00;
      else
         mc_q <= mc_q + 8'h01;
   end

   // Control and mode registers
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         tctl_q  <= `TTCU_RST;
         tmode_q <= `TTCU_RST;
         t2ctl_q <= `TTCU_RST;
         timer_two_mode_ctrl_q <= 2'h0;
      end
      else
      begin
         tctl_q  <= tctl_d;
         t2ctl_q <= t2ctl_d;
         if (wr_tmode)
            tmode_q <= WDATA;
         // Reserved mode bits are not stored, so they always read back as zero
         if (wr_timer_two_mode_ctrl)
            timer_two_mode_ctrl_q <= WDATA[1:0];
      end
   end

   // Timer 0; a software write beats a count in the same cycle
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         t0lo_q <= `TTCU_RST;
         t0hi_q <= `TTCU_RST;
      end
      else
      begin
         if (wr_t0lo)
            t0lo_q <= WDATA;
         else
            t0lo_q <= r0[7:0];
         // In split mode the high byte holds between its own machine-cycle steps
         if (wr_t0hi)
            t0hi_q <= WDATA;
         else if (en0h)
            t0hi_q <= h0[7:0];
         else if (!split)
            t0hi_q <= r0[15:8];
      end
   end

   // Timer 1; its own mode 3 holds it through the step function
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         t1lo_q <= `TTCU_RST;
         t1hi_q <= `TTCU_RST;
      end
      else
      begin
         if (wr_t1lo)
            t1lo_q <= WDATA;
         else
            t1lo_q <= r1[7:0];
         if (wr_t1hi)
            t1hi_q <= WDATA;
         else
            t1hi_q <= r1[15:8];
      end
   end

   // Timer 2 count and capture/reload registers
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cnt_q <= 16'h0000;
         cap_q <= 16'h0000;
      end
      else
      begin
         cnt_q <= cnt_d;
         cap_q <= cap_d;
      end
   end

   // Read data stand for one cycle after each cycle with RD high and are zero otherwise
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         RDATA <= 8'h00;
      else if (RD)
         RDATA <= rd_mux;
      else
         RDATA <= 8'h00;
   end

   // Timer 2 request, baud ticks and the clock-out pin
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         IRQ_T2             <= 1'b0;
         RX_BAUD_TICK       <= 1'b0;
         TX_BAUD_TICK       <= 1'b0;
         TIMER_TWO_CLK_OUT  <= 1'b0;
         TIMER_TWO_CLK_OE_N <= 1'b1;
      end
      else
      begin
         IRQ_T2 <= t2ctl_d[`TTCU_B_TF2] | t2ctl_d[`TTCU_B_TIMER_TWO_EXTERNAL_FLAG];
         // A tick lasts one cycle; the serial side divides it further
         RX_BAUD_TICK <= t2ctl_q[`TTCU_B_RXSEL] ? ovf2 : r1[16];
         TX_BAUD_TICK <= t2ctl_q[`TTCU_B_TXSEL] ? ovf2 : r1[16];
         if (clko & ovf2)
            TIMER_TWO_CLK_OUT <= ~TIMER_TWO_CLK_OUT;
         TIMER_TWO_CLK_OE_N <= ~(clko & run2);
      end
   end
endmodule

// *** dv/ttcu_monitor.sv ***
`timescale 1ns/10ps
module ttcu_monitor #(
   parameter MC_DIV = 6
)(
   input logic       MCLK,
   input logic       RSTN,
   input logic [7:0] ADDR,
   input logic [7:0] WDATA,
   input logic       WR,
   input logic       RD,
   input logic [7:0] RDATA,
   input logic       EXT_INTERRUPT_PIN_ZERO_N,
   input logic       ACK_X0,
   input logic       IRQ_X0,
   input logic       RX_BAUD_TICK,
   input logic       TX_BAUD_TICK,
   input logic       TIMER_TWO_CLK_OUT,
   input logic       TIMER_TWO_CLK_OE_N
);
   // Pin high this long means no fall is left in the sampler
   localparam int QUIET = 2 * MC_DIV + 4;
   logic [4:0] hi_cnt_q;
   logic [1:0] sel_q;
   always @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         hi_cnt_q <= 5'h00;
         sel_q    <= 2'b00;
      end
      else
      begin
         hi_cnt_q <= !EXT_INTERRUPT_PIN_ZERO_N ? 5'h00 : (hi_cnt_q == 5'h1f ? hi_cnt_q : hi_cnt_q + 5'h01);
         if (WR && ADDR == 8'hc8)
            sel_q <= WDATA[5:4];
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   clk_hold_a: assert property (TIMER_TWO_CLK_OE_N && $past(TIMER_TWO_CLK_OE_N)
      |-> $stable(TIMER_TWO_CLK_OUT)) else $error("clock output moved while disabled");
   mod_rsvd_a: assert property (RD && ADDR == 8'hc9 |=> RDATA[7:2] == 6'h00)
      else $error("reserved mode bits read nonzero");
   ctl_back_a: assert property (WR && ADDR == 8'h88 ##2 RD && ADDR == 8'h88
      |=> (RDATA & 8'h55) == ($past(WDATA, 3) & 8'h55)) else $error("control bits not kept");
   ext_ack_a: assert property (ACK_X0 && hi_cnt_q >= QUIET |=> !IRQ_X0)
      else $error("ack left external flag set");
   two_off_a: assert property (WR && ADDR == 8'hc8 && !WDATA[2] |-> ##[2:3] TIMER_TWO_CLK_OE_N)
      else $error("clock output enabled while stopped");
   rx_pulse_a: assert property (RX_BAUD_TICK |=> !RX_BAUD_TICK)
      else $error("receive tick too long");
   tx_pulse_a: assert property ($rose(TX_BAUD_TICK) |=> $fell(TX_BAUD_TICK))
      else $error("transmit tick too long");
   tick_route_a: assert property (sel_q == 2'b00 && $past(sel_q) == 2'b00
      |-> RX_BAUD_TICK == TX_BAUD_TICK) else $error("ticks differ on shared source");
   cover property (RX_BAUD_TICK);
   cover property (!TIMER_TWO_CLK_OE_N);
   cover property ($fell(IRQ_X0));
endmodule

// *** dv/ttcu_pins.sv ***
`timescale 1ns/10ps
module ttcu_pins (
   input  logic       clk,
   output logic [5:0] pin
);
   // Pins idle high, as pulled-up port pins do
   initial pin = 6'h3f;
   // Each level is held past a machine cycle, else the sampler may miss it
   task automatic pulse(input int k, input int len);
      @(posedge clk);
      pin[k] <= 1'b0;
      repeat (len) @(posedge clk);
      pin[k] <= 1'b1;
      repeat (len) @(posedge clk);
   endtask
   task automatic hold(input int k, input logic v);
      @(posedge clk);
      pin[k] <= v;
   endtask
endmodule

// *** dv/ttcu_top_test.sv ***
`timescale 1ns/10ps
module ttcu_top_test;
   logic       MCLK = 1'b0;
   logic       RSTN = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic [3:0] ack = 4'h0;
   wire  [7:0] RDATA;
   wire  [5:0] pin;
   wire  [7:0] obs;
   int         n_mismatch = 0;
   int         num_checks = 0;
   int         i;
   // Address, data written, data read back
   logic [7:0] rows [7][3] = '{'{8'h89, 8'ha5, 8'ha5}, '{8'hc9, 8'hff, 8'h03}, '{8'h88, 8'h05, 8'h05},
      '{8'h80, 8'hff, 8'h00}, '{8'hc8, 8'h08, 8'h08}, '{8'hca, 8'h3c, 8'h3c}, '{8'hc9, 8'h00, 8'h00}};
   always #5 MCLK = ~MCLK;
   ttcu_pins ttcu_pins_i (.clk(MCLK), .pin(pin));
   ttcu_top #(.MC_DIV(6)) ttcu_top_i (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .T0_COUNT_PIN(pin[0]), .T1_COUNT_PIN(pin[1]), .EXT_INTERRUPT_PIN_ZERO_N(pin[2]),
      .EXT_INTERRUPT_PIN_ONE_N(pin[3]), .TIMER_TWO_COUNT_PIN(pin[4]), .TIMER_TWO_TRIGGER_PIN(pin[5]),
      .ACK_T0(ack[0]), .ACK_T1(ack[1]), .ACK_X0(ack[2]), .ACK_X1(ack[3]), .IRQ_T0(obs[0]), .IRQ_T1(obs[1]),
      .IRQ_X0(obs[2]), .IRQ_X1(obs[3]), .IRQ_T2(obs[4]), .RX_BAUD_TICK(obs[5]), .TX_BAUD_TICK(),
      .TIMER_TWO_CLK_OE_N(obs[6]), .TIMER_TWO_CLK_OUT(obs[7]));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, e);
   endtask
   task automatic akp(input int k);
      @(posedge MCLK);
      ack[k] <= 1'b1;
      @(posedge MCLK);
      ack[k] <= 1'b0;
   endtask
   // Bounded wait for one observed output, then compare it
   task automatic wt(input int b, input logic v, input int n);
      int k;
      k = 0;
      while (obs[b] !== v && k < n)
      begin
         @(posedge MCLK);
         #1;
         k++;
      end
      chk({7'h00, obs[b]}, {7'h00, v});
   endtask
   // Whole sequence takes well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge MCLK);
      n_mismatch++;
      complete_run;
   end
   initial
   begin
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      #1;
      chk(obs, 8'h40);
      rdc(8'h88, 8'h00);
      rdc(8'hc8, 8'h00);
      for (i = 0; i < 7; i++)
      begin
         wr(rows[i][0], rows[i][1]);
         rdc(rows[i][0], rows[i][2]);
      end
      for (i = 0; i < 2; i++)
      begin
         ttcu_pins_i.pulse(2 + i, 20);
         wt(2 + i, 1'b1, 60);
         repeat (20) @(posedge MCLK);
         akp(2 + i);
         wt(2 + i, 1'b0, 3);
      end
      wr(8'h89, 8'h01);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'hff);
      wr(8'h88, 8'h10);
      wt(0, 1'b1, 30);
      rdc(8'h8c, 8'h00);
      akp(0);
      wt(0, 1'b0, 3);
      wr(8'h89, 8'h00);
      wr(8'h8b, 8'hff);
      wr(8'h8d, 8'hff);
      wr(8'h88, 8'h40);
      wt(1, 1'b1, 30);
      wr(8'h88, 8'h00);
      rdc(8'h8b, 8'he0);
      wr(8'h89, 8'h02);
      wr(8'h8c, 8'h80);
      wr(8'h8a, 8'hfe);
      wr(8'h88, 8'h10);
      wt(0, 1'b1, 30);
      wr(8'h88, 8'h00);
      rdc(8'h8a, 8'h80);
      wr(8'h89, 8'h08);
      wr(8'h8a, 8'hff);
      wr(8'h8c, 8'hff);
      ttcu_pins_i.hold(2, 1'b0);
      wr(8'h88, 8'h10);
      repeat (40) @(posedge MCLK);
      chk(obs & 8'h05, 8'h04);
      akp(2);
      repeat (12) @(posedge MCLK);
      chk(obs & 8'h05, 8'h04);
      ttcu_pins_i.hold(2, 1'b1);
      wt(0, 1'b1, 30);
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h33);
      wr(8'h8b, 8'h55);
      wr(8'h8c, 8'hfe);
      wr(8'h8a, 8'hff);
      wr(8'h88, 8'h50);
      wt(1, 1'b1, 30);
      wt(0, 1'b1, 30);
      rdc(8'h8b, 8'h55);
      wr(8'h89, 8'h05);
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      repeat (3) ttcu_pins_i.pulse(0, 8);
      repeat (12) @(posedge MCLK);
      rdc(8'h8a, 8'h03);
      wr(8'hca, 8'hf0);
      wr(8'hcb, 8'hff);
      wr(8'hcc, 8'hf0);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h34);
      wt(5, 1'b1, 40);
      repeat (40) @(posedge MCLK);
      chk(obs & 8'h10, 8'h00);
      wr(8'hc8, 8'h3c);
      ttcu_pins_i.pulse(5, 8);
      wt(4, 1'b1, 40);
      wr(8'hc8, 8'h00);
      wt(4, 1'b0, 3);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h04);
      ttcu_pins_i.pulse(5, 8);
      repeat (12) @(posedge MCLK);
      chk(obs & 8'h10, 8'h00);
      wr(8'hc8, 8'h0c);
      ttcu_pins_i.pulse(5, 8);
      wt(4, 1'b1, 40);
      rdc(8'hcd, 8'hff);
      wr(8'hc8, 8'h00);
      wr(8'hc9, 8'h02);
      wr(8'hc8, 8'h04);
      wt(6, 1'b0, 3);
      wt(7, 1'b1, 40);
      chk(obs & 8'h10, 8'h00);
      wr(8'hc8, 8'h00);
      wt(6, 1'b1, 3);
      wr(8'hc9, 8'h00);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h06);
      repeat (2) ttcu_pins_i.pulse(4, 8);
      repeat (12) @(posedge MCLK);
      rdc(8'hcc, 8'h02);
      complete_run;
   end
endmodule
bind ttcu_top ttcu_monitor #(.MC_DIV(MC_DIV)) ttcu_monitor_i (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_INTERRUPT_PIN_ZERO_N(EXT_INTERRUPT_PIN_ZERO_N),
   .ACK_X0(ACK_X0), .IRQ_X0(IRQ_X0), .RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK),
   .TIMER_TWO_CLK_OUT(TIMER_TWO_CLK_OUT), .TIMER_TWO_CLK_OE_N(TIMER_TWO_CLK_OE_N));
